// [hdl/sbwd_decode.sv]
// command load, burst sequencing and byte-write decode at the memory port
// How it works
// - direction high reads, low writes
// - direction used only with load strobe, true edge
// - address and direction captured together
// - only enabled bytes are written
// - byte enables sampled with their data beat
// - bursts of four, at most one command every four cycles
// - address ignored while deselected
// - no-op does not cut a read burst
`timescale 1ns/1ps
module sbwd_decode
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // command pins
  input wire logic load_strobe_n,
  input wire logic read_write_sel,
  input wire logic [sbwd_pkg::ADDR_W-1:0] sync_address_in,
  // write data pins
  input wire logic [sbwd_pkg::DATA_W-1:0] data_in,
  input wire logic [sbwd_pkg::NUM_BYTES-1:0] byte_write_enable_n,
  // accepted command
  output logic cmd_accept_q,
  output logic cmd_read_q,
  output logic [sbwd_pkg::ADDR_W-1:0] cmd_addr_q,
  // array read port
  output logic rd_en,
  output logic [sbwd_pkg::ADDR_W-1:0] rd_addr_q,
  // array write port
  output logic mem_we_q,
  output logic [sbwd_pkg::ADDR_W-1:0] mem_waddr_q,
  output logic [sbwd_pkg::DATA_W-1:0] mem_wdata_q,
  output logic [sbwd_pkg::NUM_BYTES-1:0] mem_wmask_q
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic ld_n_s1, ld_n_s2;
  logic rw_s1, rw_s2;
  logic [sbwd_pkg::ADDR_W-1:0] addr_s1, addr_s2;
  logic [sbwd_pkg::DATA_W-1:0] data_s1, data_s2;
  logic [sbwd_pkg::NUM_BYTES-1:0] be_n_s1, be_n_s2;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      ld_n_s1 <= 1'b1;
      ld_n_s2 <= 1'b1;
      rw_s1 <= 1'b0;
      rw_s2 <= 1'b0;
      addr_s1 <= sbwd_pkg::ADDR_RST;
      addr_s2 <= sbwd_pkg::ADDR_RST;
      data_s1 <= sbwd_pkg::DATA_RST;
      data_s2 <= sbwd_pkg::DATA_RST;
      be_n_s1 <= sbwd_pkg::BE_N_RST;
      be_n_s2 <= sbwd_pkg::BE_N_RST;
    end
    else
    begin
      ld_n_s1 <= load_strobe_n;
      ld_n_s2 <= ld_n_s1;
      rw_s1 <= read_write_sel;
      rw_s2 <= rw_s1;
      addr_s1 <= sync_address_in;
      addr_s2 <= addr_s1;
      data_s1 <= data_in;
      data_s2 <= data_s1;
      be_n_s1 <= byte_write_enable_n;
      be_n_s2 <= be_n_s1;
    end
  end

  // ----------------------------------------
  // input clock phase: each sys_clk cycle is one input clock edge
  // ----------------------------------------
  sbwd_pkg::sbwd_phase_t phase_q;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      phase_q <= sbwd_pkg::PH_TRUE;
    else
    begin
      case (phase_q)
        sbwd_pkg::PH_TRUE: phase_q <= sbwd_pkg::PH_COMP;
        default: phase_q <= sbwd_pkg::PH_TRUE;
      endcase
    end
  end

  // ----------------------------------------
  // command acceptance
  // ----------------------------------------
  logic [sbwd_pkg::CNT_W-1:0] slot_q;
  logic take;
  logic take_wr;

  // one command per burst slot, only on a true edge with the strobe low
  assign take = !ld_n_s2 && (phase_q == sbwd_pkg::PH_TRUE) && (slot_q == sbwd_pkg::CNT_ZERO);
  assign take_wr = take && !rw_s2;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      slot_q <= sbwd_pkg::CNT_ZERO;
    else if (take)
      slot_q <= sbwd_pkg::BURST_BEATS - sbwd_pkg::CNT_ONE;
    else if (slot_q != sbwd_pkg::CNT_ZERO)
      slot_q <= slot_q - sbwd_pkg::CNT_ONE;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      cmd_accept_q <= 1'b0;
      cmd_read_q <= 1'b0;
      cmd_addr_q <= sbwd_pkg::ADDR_RST;
    end
    else
    begin
      cmd_accept_q <= take;
      if (take)
      begin
        cmd_read_q <= rw_s2;
        cmd_addr_q <= addr_s2;
      end
    end
  end

  // ----------------------------------------
  // read burst: runs to its end whatever the strobe does
  // ----------------------------------------
  logic [sbwd_pkg::CNT_W-1:0] rd_left_q;

  assign rd_en = (rd_left_q != sbwd_pkg::CNT_ZERO);

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      rd_left_q <= sbwd_pkg::CNT_ZERO;
    else if (take && rw_s2)
      rd_left_q <= sbwd_pkg::BURST_BEATS;
    else if (rd_en)
      rd_left_q <= rd_left_q - sbwd_pkg::CNT_ONE;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      rd_addr_q <= sbwd_pkg::ADDR_RST;
    else if (take && rw_s2)
      rd_addr_q <= {addr_s2[sbwd_pkg::ADDR_W-1:sbwd_pkg::BEAT_W], sbwd_pkg::BEAT_ZERO};
    else if (rd_en)
      rd_addr_q[sbwd_pkg::BEAT_W-1:0] <= rd_addr_q[sbwd_pkg::BEAT_W-1:0] + sbwd_pkg::BEAT_ONE;
  end

  // ----------------------------------------
  // late write: data beats start one input cycle after the command
  // ----------------------------------------
  logic [sbwd_pkg::WR_DLY_W-1:0] wr_dly_q;
  logic [sbwd_pkg::ADDR_W-1:0] wr_pend_addr_q;
  logic [sbwd_pkg::ADDR_W-1:0] wr_base_q;
  logic [sbwd_pkg::CNT_W-1:0] wr_left_q;
  logic wr_live;
  logic [sbwd_pkg::BEAT_W-1:0] wr_idx;
  logic [sbwd_pkg::CNT_W-1:0] wr_done;

  assign wr_live = (wr_left_q != sbwd_pkg::CNT_ZERO);
  assign wr_done = sbwd_pkg::BURST_BEATS - wr_left_q;
  assign wr_idx = wr_done[sbwd_pkg::BEAT_W-1:0];

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      wr_dly_q <= sbwd_pkg::WR_DLY_RST;
    else
      wr_dly_q <= {wr_dly_q[0], take_wr};
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      wr_pend_addr_q <= sbwd_pkg::ADDR_RST;
    else if (take_wr)
      wr_pend_addr_q <= addr_s2;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      wr_left_q <= sbwd_pkg::CNT_ZERO;
      wr_base_q <= sbwd_pkg::ADDR_RST;
    end
    else if (wr_dly_q[0])
    begin
      wr_left_q <= sbwd_pkg::BURST_BEATS;
      wr_base_q <= {wr_pend_addr_q[sbwd_pkg::ADDR_W-1:sbwd_pkg::BEAT_W], sbwd_pkg::BEAT_ZERO};
    end
    else if (wr_live)
      wr_left_q <= wr_left_q - sbwd_pkg::CNT_ONE;
  end

  // each beat takes its byte enables from the same edge as its data
  sbwd_byte_merge u_merge
  (
    .sys_clk(sys_clk),
    .rst(rst),
    .beat_valid(wr_live),
    .beat_addr({wr_base_q[sbwd_pkg::ADDR_W-1:sbwd_pkg::BEAT_W], wr_idx}),
    .beat_data(data_s2),
    .beat_be_n(be_n_s2),
    .mem_we_q(mem_we_q),
    .mem_waddr_q(mem_waddr_q),
    .mem_wdata_q(mem_wdata_q),
    .mem_wmask_q(mem_wmask_q)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  cmd_take_a: assert property (@(posedge sys_clk) disable iff (rst)
    cmd_accept_q |-> !$past(ld_n_s2) && ($past(phase_q) == sbwd_pkg::PH_TRUE))
    else $error("command taken without strobe or off the true edge");

  cmd_dir_a: assert property (@(posedge sys_clk) disable iff (rst)
    cmd_accept_q |-> (cmd_read_q == $past(rw_s2)))
    else $error("command direction not taken from direction input");

  cmd_addr_a: assert property (@(posedge sys_clk) disable iff (rst)
    cmd_accept_q |-> (cmd_addr_q == $past(addr_s2)))
    else $error("command address not captured with direction");

  cmd_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    !cmd_accept_q |-> $stable(cmd_addr_q) && $stable(cmd_read_q))
    else $error("latched command changed without a load");

  deselect_a: assert property (@(posedge sys_clk) disable iff (rst)
    $past(ld_n_s2) |-> !cmd_accept_q)
    else $error("command accepted while deselected");

  cmd_space_a: assert property (@(posedge sys_clk) disable iff (rst)
    cmd_accept_q |=> !cmd_accept_q [*3])
    else $error("commands closer than one burst");

  rd_burst_a: assert property (@(posedge sys_clk) disable iff (rst)
    (cmd_accept_q && cmd_read_q) |-> rd_en [*4] ##1 !rd_en || cmd_accept_q)
    else $error("read burst not four beats");

  wr_beats_a: assert property (@(posedge sys_clk) disable iff (rst)
    (cmd_accept_q && !cmd_read_q) |-> ##1 wr_live [*4])
    else $error("write beats not one input cycle after command");

  wr_first_a: assert property (@(posedge sys_clk) disable iff (rst)
    wr_dly_q[1] |-> wr_live && (wr_idx == sbwd_pkg::BEAT_ZERO))
    else $error("first write beat not on the edge after the load");

  wr_phase_a: assert property (@(posedge sys_clk) disable iff (rst)
    wr_live |-> (wr_idx[0] == (phase_q == sbwd_pkg::PH_COMP)))
    else $error("write beat on wrong input clock edge");

endmodule : sbwd_decode

// [include/sbwd_pkg.sv]
// constants for the memory command and byte-write decode block
package sbwd_pkg;
  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int ADDR_W = 20;
  localparam int DATA_W = 36;
  localparam int BYTE_W = 9;
  localparam int NUM_BYTES = 4;
  localparam int BEAT_W = 2;
  localparam int CNT_W = 3;
  localparam int WR_DLY_W = 2;
  // ----------------------------------------
  // burst timing, in sys_clk beats (one beat per input clock edge)
  // ----------------------------------------
  localparam logic [CNT_W-1:0] BURST_BEATS = 3'h4;
  localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 3'h1;
  localparam logic [BEAT_W-1:0] BEAT_ZERO = 2'h0;
  localparam logic [BEAT_W-1:0] BEAT_ONE = 2'h1;
  localparam logic [WR_DLY_W-1:0] WR_DLY_RST = 2'h0;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_RST = 20'h00000;
  localparam logic [DATA_W-1:0] DATA_RST = 36'h000000000;
  localparam logic [NUM_BYTES-1:0] MASK_RST = 4'h0;
  localparam logic [NUM_BYTES-1:0] BE_N_RST = 4'hf;
  // ----------------------------------------
  // input clock phase: true edge or complement edge
  // ----------------------------------------
  typedef enum logic {PH_TRUE, PH_COMP} sbwd_phase_t;
endpackage : sbwd_pkg

// [hdl/sbwd_byte_merge.sv]
// per-byte write qualification of one write beat
`timescale 1ns/1ps
module sbwd_byte_merge
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // beat in
  input wire logic beat_valid,
  input wire logic [sbwd_pkg::ADDR_W-1:0] beat_addr,
  input wire logic [sbwd_pkg::DATA_W-1:0] beat_data,
  input wire logic [sbwd_pkg::NUM_BYTES-1:0] beat_be_n,
  // array write port
  output logic mem_we_q,
  output logic [sbwd_pkg::ADDR_W-1:0] mem_waddr_q,
  output logic [sbwd_pkg::DATA_W-1:0] mem_wdata_q,
  output logic [sbwd_pkg::NUM_BYTES-1:0] mem_wmask_q
);

  logic [sbwd_pkg::DATA_W-1:0] gated_d;

  // ----------------------------------------
  // byte gating: disabled bytes carry zero and no mask bit
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < sbwd_pkg::NUM_BYTES; gi++)
    begin : g_byte
      assign gated_d[gi*sbwd_pkg::BYTE_W +: sbwd_pkg::BYTE_W] =
        beat_be_n[gi] ? {sbwd_pkg::BYTE_W{1'b0}} : beat_data[gi*sbwd_pkg::BYTE_W +: sbwd_pkg::BYTE_W];
    end
  endgenerate

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      mem_we_q <= 1'b0;
      mem_waddr_q <= sbwd_pkg::ADDR_RST;
      mem_wdata_q <= sbwd_pkg::DATA_RST;
      mem_wmask_q <= sbwd_pkg::MASK_RST;
    end
    else
    begin
      mem_we_q <= beat_valid;
      mem_waddr_q <= beat_addr;
      mem_wdata_q <= gated_d;
      mem_wmask_q <= beat_valid ? ~beat_be_n : sbwd_pkg::MASK_RST;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  byte_mask_a: assert property (@(posedge sys_clk) disable iff (rst)
    mem_we_q |-> (mem_wmask_q == ~$past(beat_be_n)) && (mem_waddr_q == $past(beat_addr)))
    else $error("byte mask does not follow byte write enables");

endmodule : sbwd_byte_merge

// [tb/sbwd_ctl_model.sv]
// memory controller model: commands, direction and masked write beats
`timescale 1ns/1ps
module sbwd_ctl_model
(
  // clock and answer
  input wire logic sys_clk,
  input wire logic cmd_accept_q,
  // command and data pins
  output logic load_strobe_n,
  output logic read_write_sel,
  output logic [sbwd_pkg::ADDR_W-1:0] sync_address_in,
  output logic [sbwd_pkg::DATA_W-1:0] data_in,
  output logic [sbwd_pkg::NUM_BYTES-1:0] byte_write_enable_n
);
  logic q_rd [8];
  logic [19:0] q_addr [8];
  logic [35:0] q_data [8][4];
  logic [3:0] q_be [8][4];
  int tmo = 0;
  initial
  begin
    load_strobe_n = 1'b1;
    read_write_sel = 1'b0;
    sync_address_in = 20'h00000;
    data_in = 36'h000000000;
    byte_write_enable_n = 4'hf;
  end
  // strobe stays low across back to back commands; beat 0 stands until the accept is seen
  task automatic run(input int n);
    int w;
    load_strobe_n = 1'b0;
    read_write_sel = q_rd[0];
    sync_address_in = q_addr[0];
    data_in = q_rd[0] ? ~data_in : q_data[0][0];
    byte_write_enable_n = q_rd[0] ? ~byte_write_enable_n : q_be[0][0];
    for (int i = 0; i < n; i++)
    begin
      w = 0;
      do
      begin
        @(posedge sys_clk);
        #1;
        w++;
      end while (cmd_accept_q !== 1'b1 && w < 20);
      if (w >= 20)
        tmo++;
      load_strobe_n = (i + 1 >= n);
      read_write_sel = (i + 1 < n) ? q_rd[i+1] : ~read_write_sel;
      sync_address_in = (i + 1 < n) ? q_addr[i+1] : ~sync_address_in;
      for (int j = 1; j < 4; j++)
      begin
        if (j > 1)
          @(posedge sys_clk);
        if (j > 1)
          #1;
        data_in = q_rd[i] ? ~data_in : q_data[i][j];
        byte_write_enable_n = q_rd[i] ? ~byte_write_enable_n : q_be[i][j];
      end
      @(posedge sys_clk);
      #1;
      data_in = (i + 1 >= n || q_rd[i+1]) ? ~data_in : q_data[i+1][0];
      byte_write_enable_n = (i + 1 >= n || q_rd[i+1]) ? ~byte_write_enable_n : q_be[i+1][0];
    end
  endtask : run
endmodule : sbwd_ctl_model

// [tb/tb.sv]
// testbench for command decode, read bursts and masked write beats
`timescale 1ns/1ps
module tb;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic ld_n, rw, acc_q, rd_q, rd_en, we_q;
  logic [19:0] sa, ca, ra, wa, a;
  logic [35:0] din, wd, md;
  logic [3:0] be_n, wm;
  int error_cnt = 0;
  int checked = 0;
  int acc = 0;
  int cyc = 0;
  int s, t;
  logic ev_rd [16];
  logic ev_we [16];
  logic [19:0] ev_ra [16];
  logic [19:0] ev_wa [16];
  logic [35:0] ev_d [16];
  logic [3:0] ev_m [16];
  always #2.5 sys_clk = ~sys_clk;
  sbwd_ctl_model u_ctl (.sys_clk(sys_clk), .cmd_accept_q(acc_q), .load_strobe_n(ld_n),
    .read_write_sel(rw), .sync_address_in(sa), .data_in(din), .byte_write_enable_n(be_n));
  sbwd_decode dut (.sys_clk(sys_clk), .rst(rst), .load_strobe_n(ld_n), .read_write_sel(rw),
    .sync_address_in(sa), .data_in(din), .byte_write_enable_n(be_n), .cmd_accept_q(acc_q),
    .cmd_read_q(rd_q), .cmd_addr_q(ca), .rd_en(rd_en), .rd_addr_q(ra), .mem_we_q(we_q),
    .mem_waddr_q(wa), .mem_wdata_q(wd), .mem_wmask_q(wm));
  task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
    checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // ----------------------------------------
  // expected beats, scheduled at each accept
  // ----------------------------------------
  always @(posedge sys_clk)
  begin
    #2;
    s = cyc % 16;
    if (rst === 1'b0 && acc_q === 1'b1)
    begin
      chk("cmd_read_q", u_ctl.q_rd[acc], rd_q);
      chk("cmd_addr_q", u_ctl.q_addr[acc], ca);
      for (int j = 0; j < 4; j++)
      begin
        t = u_ctl.q_rd[acc] ? (s + j) % 16 : (s + 2 + j) % 16;
        a = {u_ctl.q_addr[acc][19:2], 2'(j)};
        md = u_ctl.q_data[acc][j];
        for (int b = 0; b < 4; b++)
          if (u_ctl.q_be[acc][j][b])
            md[b*9+:9] = 9'h000;
        if (u_ctl.q_rd[acc])
          ev_ra[t] = a;
        else
        begin
          ev_wa[t] = a;
          ev_d[t] = md;
          ev_m[t] = ~u_ctl.q_be[acc][j];
        end
        ev_rd[t] = ev_rd[t] | u_ctl.q_rd[acc];
        ev_we[t] = ev_we[t] | ~u_ctl.q_rd[acc];
      end
      acc++;
    end
    if (rst === 1'b0)
    begin
      chk("rd_en", ev_rd[s], rd_en);
      if (ev_rd[s])
        chk("rd_addr_q", ev_ra[s], ra);
      chk("mem_we_q", ev_we[s], we_q);
      chk("mem_wmask_q", ev_we[s] ? ev_m[s] : 4'h0, wm);
      if (ev_we[s])
        chk("mem_waddr_q", ev_wa[s], wa);
      if (ev_we[s])
        chk("mem_wdata_q", ev_d[s], wd);
    end
    ev_rd[s] = 1'b0;
    ev_we[s] = 1'b0;
    cyc++;
  end
  task automatic load(input int i, input logic r, input logic [19:0] ad, input logic [3:0] k);
    u_ctl.q_rd[i] = r;
    u_ctl.q_addr[i] = ad;
    for (int j = 0; j < 4; j++)
    begin
      u_ctl.q_data[i][j] = {4{9'(k * 37 + j * 11)}};
      u_ctl.q_be[i][j] = 4'(j * 5) ^ k;
    end
  endtask : load
  task automatic go(input int n, input string nm);
    acc = 0;
    u_ctl.run(n);
    repeat (10) @(posedge sys_clk);
    #1;
    chk("accepts", n, acc);
    chk("held addr", u_ctl.q_addr[n-1], ca);
    chk("held dir", u_ctl.q_rd[n-1], rd_q);
    chk("timeout", 0, u_ctl.tmo);
    $display("done %s", nm);
  endtask : go
  task automatic t_write;
    load(0, 1'b0, 20'h12344, 4'h0);
    go(1, "masked write");
  endtask : t_write
  task automatic t_read;
    load(0, 1'b1, 20'habcd8, 4'h3);
    go(1, "read burst");
  endtask : t_read
  task automatic t_b2b;
    load(0, 1'b0, 20'h00010, 4'h6);
    load(1, 1'b0, 20'hfff0c, 4'h9);
    load(2, 1'b1, 20'h55554, 4'h1);
    load(3, 1'b1, 20'h00000, 4'h2);
    go(4, "back to back");
  endtask : t_b2b
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : complete_run
  initial
  begin
    #20000;
    error_cnt++;
    complete_run();
  end
  initial
  begin
    foreach (ev_rd[i])
    begin
      ev_rd[i] = 1'b0;
      ev_we[i] = 1'b0;
    end
    repeat (6) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    t_write();
    t_read();
    t_b2b();
    complete_run();
  end
endmodule : tb
